// >>> rtl/sob_pkg.sv
// Constants, carrier types and field layout of the safety output block
// Behaviour
// - Dual output follows logic input level
// - Restart option needs restart after input falls
// - Manual restart accepts rising restart edge
// - Monitored restart needs rise then fall
// - Status export shows current output state
// - Contactor check watches feedback within window
// - Feedback timeout forces output low, lamp flashes
// - Error output flags feedback timing error
// - Error latched until power or master reset
// - Each output pair has restart feedback input
// - Single output follows logic input level
// - Single output feedback input shown when needed
// - Four channels: four single, two double, mixed
// - Status signal output follows its input
// - Closed guard enables outputs, opening drops them
package sob_pkg;

  localparam int NCH = 4;
  localparam int PIN_W = 12;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_WINDOW = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

  localparam int CTRL_W = 26;
  localparam int CTRL_RESTART_LSB = 0;
  localparam int CTRL_MONITORED_LSB = 4;
  localparam int CTRL_CHECK_LSB = 8;
  localparam int CTRL_EXPORT_LSB = 12;
  localparam int CTRL_ERROUT_LSB = 16;
  localparam int CTRL_GUARD_LSB = 20;
  localparam int CTRL_CONFIG_LSB = 24;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 26'h0000000;

  localparam int WIN_W = 16;
  localparam logic [WIN_W-1:0] WINDOW_RESET = 16'h0064;

  localparam int STAT_OUT_LSB = 0;
  localparam int STAT_ERR_LSB = 4;
  localparam int STAT_USED_LSB = 8;
  localparam int STAT_GUARD_BIT = 12;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLOCK_NS = 40;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLOCK_NS;
  localparam int BLINK_MS = 250;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {SOB_FOUR_SINGLE, SOB_TWO_DOUBLE, SOB_MIXED} sob_config_t;
  typedef enum logic [1:0] {ST_OFF, ST_ARMED, ST_ON} sob_state_t;

  typedef struct packed {
    logic [1:0] cfg;
    logic [3:0] guard_en;
    logic [3:0] errout_en;
    logic [3:0] export_en;
    logic [3:0] check_en;
    logic [3:0] monitored;
    logic [3:0] restart_en;
  } sob_ctrl_t;

endpackage

// >>> rtl/sob_safety_output.sv
// Safety output block: restart, contactor check, error latch, AXI4-Lite registers
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
module sob_safety_output
  import sob_pkg::*;
#(
  parameter int MS_TICKS = MS_CYCLES,
  parameter int BLINK_TICKS = BLINK_MS,
  parameter bit ALWAYS_RF_INPUT = 1'b0
) (
  input wire logic clock, // System clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic ce, // Clock enable
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [3:0] logic_in, // Logic input per channel
  input wire logic [3:0] restart_feedback, // Restart and feedback pins
  input wire logic gate_closed, // First gate contact
  input wire logic gate_open, // Second gate contact
  input wire logic status_signal_in, // Non-safety status source
  input wire logic master_reset_operator, // Clears latched errors
  output logic [3:0] safety_output, // Safety output channels
  output logic [3:0] state_export, // Exported output state
  output logic [3:0] error_out, // Feedback error flags
  output logic [3:0] output_indicator_lamp, // Flashes on feedback error
  output logic [3:0] feedback_input_used, // Restart feedback input in use
  output logic guard_monitor, // Guard closed and healthy
  output logic status_signal_out, // Non-safety status output
  output logic irq // Interrupt, level
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [PIN_W-1:0] pin_raw, sync1, sync2, sync3, pin_f;
  assign pin_raw = {master_reset_operator, status_signal_in, gate_open, gate_closed,
                    restart_feedback, logic_in};

  always_ff @(posedge clock) begin
    if (reset) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      pin_f <= '0;
    end else if (ce) begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      // A change counts only once two stages agree
      for (int b = 0; b < PIN_W; b++) begin
        if (sync2[b] == sync3[b]) begin
          pin_f[b] <= sync3[b];
        end
      end
    end
  end

  wire logic [3:0] lin_f = pin_f[3:0];
  wire logic [3:0] rf_f = pin_f[7:4];
  wire logic guard_ok = pin_f[8] & ~pin_f[9];
  wire logic status_f = pin_f[10];
  wire logic mr_f = pin_f[11];

  // ------------------------------------------------------------
  // Registers and channel state
  // ------------------------------------------------------------
  sob_ctrl_t ctrl;
  logic [WIN_W-1:0] window;
  logic [3:0] irq_stat, irq_mask;
  sob_state_t state [NCH];
  sob_state_t next_state [NCH];
  logic [3:0] err, next_err, rf_prev, mismatch, next_on;
  logic [WIN_W-1:0] tmr [NCH];
  logic [WIN_W-1:0] next_tmr [NCH];
  logic [31:0] ms_cnt, blink_cnt;
  logic blink;
  wire logic ms_tick = (ms_cnt == 32'(MS_TICKS - 1));

  // Lead channel whose block drives channel i in the chosen layout
  function automatic int lead_of(input logic [1:0] cfg, input int i);
    if (cfg == SOB_TWO_DOUBLE) begin
      return i - (i % 2);
    end else if (cfg == SOB_MIXED && i >= 2) begin
      return 2;
    end
    return i;
  endfunction

  wire logic [3:0] rf_rise = rf_f & ~rf_prev;
  wire logic [3:0] rf_fall = ~rf_f & rf_prev;
  wire logic [3:0] eff_in = lin_f & (~ctrl.guard_en | {NCH{guard_ok}});

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      next_state[i] = state[i];
      next_tmr[i] = tmr[i];
      // Contactor feedback must sit opposite to the output
      mismatch[i] = ctrl.check_en[i] & (rf_f[i] == (state[i] == ST_ON));
      if (!mismatch[i]) begin
        next_tmr[i] = '0;
      end else if (ms_tick && tmr[i] != window) begin
        next_tmr[i] = tmr[i] + 1'b1;
      end
      next_err[i] = err[i] & ~mr_f | mismatch[i] & ms_tick & (tmr[i] >= window);
      if (next_err[i] || !eff_in[i]) begin
        next_state[i] = ST_OFF;
      end else begin
        case (state[i])
          ST_OFF: begin
            if (!ctrl.restart_en[i]) begin
              next_state[i] = ST_ON;
            end else if (rf_rise[i]) begin
              next_state[i] = ctrl.monitored[i] ? ST_ARMED : ST_ON;
            end
          end
          ST_ARMED: begin
            if (rf_fall[i] || !ctrl.restart_en[i]) begin
              next_state[i] = ST_ON;
            end
          end
          default: next_state[i] = ST_ON;
        endcase
      end
      next_on[i] = (next_state[i] == ST_ON);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ms_cnt <= '0;
      blink_cnt <= '0;
      blink <= 1'b0;
    end else if (ce) begin
      ms_cnt <= ms_tick ? '0 : ms_cnt + 1'b1;
      if (ms_tick) begin
        blink_cnt <= (blink_cnt == 32'(BLINK_TICKS - 1)) ? '0 : blink_cnt + 1'b1;
        blink <= (blink_cnt == 32'(BLINK_TICKS - 1)) ? ~blink : blink;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < NCH; i++) begin
        state[i] <= ST_OFF;
        tmr[i] <= '0;
      end
      err <= '0;
      rf_prev <= '0;
    end else if (ce) begin
      for (int i = 0; i < NCH; i++) begin
        state[i] <= next_state[i];
        tmr[i] <= next_tmr[i];
      end
      err <= next_err;
      rf_prev <= rf_f;
    end
  end

  // ------------------------------------------------------------
  // Registered outputs, mapped through the channel layout
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      safety_output <= '0;
      state_export <= '0;
      error_out <= '0;
      output_indicator_lamp <= '0;
      feedback_input_used <= '0;
      guard_monitor <= 1'b0;
      status_signal_out <= 1'b0;
    end else if (ce) begin
      for (int i = 0; i < NCH; i++) begin
        safety_output[i] <= next_on[lead_of(ctrl.cfg, i)];
        state_export[i] <= next_on[lead_of(ctrl.cfg, i)] & ctrl.export_en[i];
        error_out[i] <= next_err[lead_of(ctrl.cfg, i)] & ctrl.errout_en[i];
        output_indicator_lamp[i] <= next_err[lead_of(ctrl.cfg, i)] & blink;
        // A double uses its lead's pin always; singles only with restart or check
        feedback_input_used[i] <= ALWAYS_RF_INPUT | (lead_of(ctrl.cfg, i) == i
          && (ctrl.restart_en[i] || ctrl.check_en[i] || lead_of(ctrl.cfg, i | 1) != (i | 1)));
      end
      guard_monitor <= guard_ok;
      status_signal_out <= status_f;
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------
  logic aw_full, w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire logic do_write = aw_full & w_full & ~s_axi_bvalid;
  wire logic wr_ctrl = do_write && aw_addr == ADDR_CTRL;
  wire logic wr_win = do_write && aw_addr == ADDR_WINDOW;
  wire logic wr_stat = do_write && aw_addr == ADDR_IRQ_STAT;
  wire logic wr_mask = do_write && aw_addr == ADDR_IRQ_MASK;
  wire logic wr_ro = do_write && aw_addr == ADDR_STATUS;
  wire logic [31:0] bytemask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire logic [31:0] ctrl_merge = (32'(ctrl) & ~bytemask) | (w_data & bytemask);
  wire logic [3:0] err_event = next_err & ~err;
  wire logic [3:0] w1c = wr_stat ? (w_data[3:0] & {4{w_strb[0]}}) : 4'h0;
  wire logic [3:0] next_irq_stat = (irq_stat & ~w1c) | err_event;
  wire logic [31:0] status_word = {19'h0, guard_ok, feedback_input_used, err, safety_output};
  wire logic [31:0] rd_word =
    (s_axi_araddr == ADDR_CTRL) ? 32'(ctrl) :
    (s_axi_araddr == ADDR_WINDOW) ? 32'(window) :
    (s_axi_araddr == ADDR_STATUS) ? status_word :
    (s_axi_araddr == ADDR_IRQ_STAT) ? 32'(irq_stat) :
    (s_axi_araddr == ADDR_IRQ_MASK) ? 32'(irq_mask) : 32'h0;
  wire logic rd_hit = s_axi_araddr == ADDR_CTRL || s_axi_araddr == ADDR_WINDOW
    || s_axi_araddr == ADDR_STATUS || s_axi_araddr == ADDR_IRQ_STAT
    || s_axi_araddr == ADDR_IRQ_MASK;

  always_ff @(posedge clock) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else if (ce) begin
      s_axi_awready <= s_axi_awvalid & ~s_axi_awready & ~aw_full;
      s_axi_wready <= s_axi_wvalid & ~s_axi_wready & ~w_full;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_ctrl | wr_win | wr_stat | wr_mask | wr_ro) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl <= CTRL_RESET;
      window <= WINDOW_RESET;
      irq_stat <= '0;
      irq_mask <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl <= ctrl_merge[CTRL_W-1:0];
      end
      if (wr_win) begin
        window <= (window & ~bytemask[WIN_W-1:0]) | (w_data[WIN_W-1:0] & bytemask[WIN_W-1:0]);
      end
      if (wr_mask) begin
        irq_mask <= w_strb[0] ? w_data[3:0] : irq_mask;
      end
      // New error beats a simultaneous clear
      irq_stat <= next_irq_stat;
      irq <= |(next_irq_stat & (wr_mask && w_strb[0] ? w_data[3:0] : irq_mask));
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Assertions on channel 0, always a lead; power-up check covers all four outputs
  // ------------------------------------------------------------
  property p_off_when_low;
    @(posedge clock) disable iff (reset) ce && !eff_in[0] |=> !safety_output[0];
  endproperty
  a_off_when_low: assert property (p_off_when_low) else $error("output on with input low");

  property p_direct_follow;
    @(posedge clock) disable iff (reset)
      ce && !ctrl.restart_en[0] && eff_in[0] && !next_err[0] |=> safety_output[0];
  endproperty
  a_direct_follow: assert property (p_direct_follow) else $error("no direct follow");

  property p_manual_edge;
    @(posedge clock) disable iff (reset)
      ce && ctrl.restart_en[0] && state[0] == ST_OFF && !rf_rise[0] |=> !safety_output[0];
  endproperty
  a_manual_edge: assert property (p_manual_edge) else $error("start without rise");

  property p_monitored;
    @(posedge clock) disable iff (reset)
      ce && ctrl.restart_en[0] && ctrl.monitored[0] && state[0] == ST_OFF
      |=> !safety_output[0] ##1 (!ce || !safety_output[0] || $past(rf_fall[0]));
  endproperty
  a_monitored: assert property (p_monitored) else $error("monitored restart too early");

  property p_export;
    @(posedge clock) disable iff (reset)
      ce |=> state_export[0] == (safety_output[0] && $past(ctrl.export_en[0]));
  endproperty
  a_export: assert property (p_export) else $error("export differs from output");

  property p_timeout;
    @(posedge clock) disable iff (reset)
      ce && ms_tick && mismatch[0] && tmr[0] >= window |=> err[0] && !safety_output[0];
  endproperty
  a_timeout: assert property (p_timeout) else $error("window overrun not caught");

  property p_err_forces_off;
    @(posedge clock) disable iff (reset) err[0] |-> !safety_output[0];
  endproperty
  a_err_forces_off: assert property (p_err_forces_off) else $error("output on in error");

  property p_errout;
    @(posedge clock) disable iff (reset) error_out[0] |-> err[0];
  endproperty
  a_errout: assert property (p_errout) else $error("error out without error");

  property p_latch;
    @(posedge clock) disable iff (reset) err[0] && !mr_f |=> err[0];
  endproperty
  a_latch: assert property (p_latch) else $error("error cleared early");

  property p_status_sig;
    @(posedge clock) disable iff (reset) ce |=> status_signal_out == $past(status_f);
  endproperty
  a_status_sig: assert property (p_status_sig) else $error("status output wrong");

  property p_power_up;
    @(posedge clock) $past(reset) |-> safety_output == 4'h0 && error_out == 4'h0;
  endproperty
  a_power_up: assert property (p_power_up) else $error("outputs not off after reset");

endmodule // sob_safety_output

// >>> tb/sob_contactor.sv
// Partner model: external contactors with feedback contact and restart button
`timescale 1ns/1ns
module sob_contactor #(
  parameter int DELAY = 6
) (
  input wire logic clock, // System clock
  input wire logic [3:0] safety_output, // Coil drive per channel
  input wire logic [3:0] press, // Restart pushbutton held
  input wire logic [3:0] stuck, // Welded contact, feedback frozen
  output logic [3:0] restart_feedback // Button in series with feedback contact
);
  logic [3:0] pipe [DELAY];
  logic [3:0] fb_now;

  initial begin
    fb_now = 4'hf;
    for (int i = 0; i < DELAY; i++) begin
      pipe[i] = 4'hf;
    end
  end

  // Contact opens late after the coil moves; welded contact holds
  always @(posedge clock) begin
    pipe[0] <= ~safety_output;
    for (int i = 1; i < DELAY; i++) begin
      pipe[i] <= pipe[i-1];
    end
    fb_now <= (stuck & fb_now) | (~stuck & pipe[DELAY-1]);
  end

  // Shared pin: button reads through the feedback contact
  assign restart_feedback = press & fb_now;
endmodule // sob_contactor

// >>> tb/tb.sv
// Testbench: safety output block against fixed expected values, with a contactor model
`timescale 1ns/1ns
module tb;
  import sob_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] logic_in = 4'h0, press = 4'h0, stuck = 4'h0;
  logic gate_closed = 1'b0, gate_open = 1'b1, status_in = 1'b0, mro = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, guard_mon, status_out, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [3:0] rf, so, sx, eo, lamp, fu;
  logic [31:0] seed = 32'h8de86930;
  int bad_count = 0, num_checks = 0, cycles = 0, ones;

  sob_safety_output #(.MS_TICKS(4), .BLINK_TICKS(2)) sob_safety_output_inst (
    .clock(clock), .reset(reset), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .logic_in(logic_in), .restart_feedback(rf), .gate_closed(gate_closed),
    .gate_open(gate_open), .status_signal_in(status_in), .master_reset_operator(mro),
    .safety_output(so), .state_export(sx), .error_out(eo), .output_indicator_lamp(lamp),
    .feedback_input_used(fu), .guard_monitor(guard_mon), .status_signal_out(status_out),
    .irq(irq));

  sob_contactor #(.DELAY(6)) sob_contactor_inst (
    .clock(clock), .safety_output(so), .press(press), .stuck(stuck),
    .restart_feedback(rf));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  initial begin
    forever #20 clock = ~clock;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp = bresp;
  endtask

  task automatic axi_read(input logic [7:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    resp = rresp;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      $display("MISMATCH t=%0t run did not finish", $time);
      summarize();
    end
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    cyc(6);
    chk(so, 4'h0);
    chk(eo, 4'h0);
    axi_read(ADDR_CTRL);
    chk(rd, 32'h0);
    axi_read(ADDR_WINDOW);
    chk(rd, 32'h64);
    axi_read(8'h40);
    chk(resp, RESP_SLVERR);
    axi_write(8'h40, 32'h0);
    chk(resp, RESP_SLVERR);
    axi_write(ADDR_CTRL, 32'h0000f000);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      logic_in <= seed[3:0];
      status_in <= seed[4];
      cyc(8);
      chk(so, logic_in);
      chk(sx, logic_in);
      chk(status_out, status_in);
    end
    // Restart: monitored on channel 0, manual on channel 1
    logic_in <= 4'h0;
    axi_write(ADDR_CTRL, 32'h0000f013);
    logic_in <= 4'h3;
    cyc(10);
    chk(so[1:0], 2'h0);
    press <= 4'h3;
    cyc(8);
    chk(so[1:0], 2'h2);
    chk(fu, 4'h3);
    press <= 4'h0;
    cyc(8);
    chk(so[1:0], 2'h3);
    logic_in <= 4'h0;
    cyc(8);
    logic_in <= 4'h3;
    cyc(10);
    chk(so[1:0], 2'h0);
    // Contactor check: channel 2 welded, channel 3 healthy
    logic_in <= 4'h0;
    // Auto-restart channels: pin wired to the contact alone
    press <= 4'hc;
    axi_write(ADDR_WINDOW, 32'h3);
    axi_write(ADDR_IRQ_MASK, 32'h4);
    axi_write(ADDR_CTRL, 32'h000c0c00);
    stuck <= 4'h4;
    logic_in <= 4'hc;
    cyc(6);
    chk(so[3:2], 2'h3);
    cyc(60);
    chk(so[3:2], 2'h2);
    chk(eo, 4'h4);
    chk(fu, 4'hc);
    chk(irq, 1'b1);
    ones = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clock);
      ones += lamp[2];
    end
    chk(ones > 0 && ones < 40, 1'b1);
    axi_read(ADDR_IRQ_STAT);
    chk(rd[3:0], 4'h4);
    axi_write(ADDR_IRQ_STAT, 32'h4);
    cyc(3);
    chk(irq, 1'b0);
    logic_in <= 4'h0;
    stuck <= 4'h0;
    cyc(20);
    chk(eo, 4'h4);
    mro <= 1'b1;
    cyc(8);
    mro <= 1'b0;
    cyc(8);
    chk(eo, 4'h0);
    // Guard gating
    axi_write(ADDR_CTRL, 32'h00f00000);
    logic_in <= 4'hf;
    gate_closed <= 1'b1;
    gate_open <= 1'b0;
    cyc(8);
    chk(guard_mon, 1'b1);
    chk(so, 4'hf);
    gate_closed <= 1'b0;
    gate_open <= 1'b1;
    cyc(8);
    chk(so, 4'h0);
    chk(guard_mon, 1'b0);
    // Layouts: followers copy their lead
    axi_write(ADDR_CTRL, 32'h01000000);
    logic_in <= 4'h5;
    cyc(8);
    chk(so, 4'hf);
    chk(fu, 4'h5);
    axi_write(ADDR_CTRL, 32'h02000000);
    logic_in <= 4'h6;
    cyc(8);
    chk(so, 4'he);
    chk(fu, 4'h4);
    summarize();
  end
endmodule // tb
